// [shared/adc_chain_cfg.svh]
`ifndef ADC_CHAIN_CFG_SVH
`define ADC_CHAIN_CFG_SVH
// word and clock figures
`define ADC_WORD_BITS 12
`define ADC_CLK_HZ 100000000
`define ADC_INT_CLK_NS 820
`define ADC_INT_HALF_CYC ((`ADC_INT_CLK_NS * (`ADC_CLK_HZ / 1000000)) / 2000)
`define ADC_CODE_POS_FS 12'h07ff
`define ADC_CODE_NEG_FS 12'h0800
`endif

// [shared/adc_pkg.sv]
package adc_pkg;
  typedef enum logic [1:0] {
    ADC_IDLE,
    ADC_INT_HI,
    ADC_INT_LO
  } adc_int_state_e;
endpackage

// [hw/adc_chain.sv]
`timescale 1ns/1ps
`include "adc_chain_cfg.svh"
// Behaviour
// - shift word then chain bits on external clock
// - one separator bit between chained words
// - chain level sampled at start, shown at end
// - internal mode holds captured chain level afterwards
// - grounded first chain input gives zero separators
// - out-of-range input clamps to full scale
// - msb shown at load, chain bit after twelfth fall
module adc_chain #(
  parameter int WORD_BITS = `ADC_WORD_BITS
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // link pins, asynchronous
  input wire logic i_shift_clock_pin,
  input wire logic i_chain_in,
  input wire logic i_chip_sel_n,
  input wire logic i_read_conv_n,
  input wire logic i_ext_clk_sel,
  // conversion result from the converter core
  input wire logic i_result_load,
  input wire logic signed [WORD_BITS:0] i_result_raw,
  // serial side
  output logic o_serial_output,
  output logic o_int_clock,
  output logic o_busy
);
  localparam logic [4:0] LAST_BIT = 5'(WORD_BITS - 1);

  // internal clock level decode, shared by the tick and the pin
  function automatic logic adc_int_high(input adc_pkg::adc_int_state_e s);
    return s == adc_pkg::ADC_INT_HI;
  endfunction

  // two-stage synchronisers for every pin
  // no reset here: a reset of two cycles flushes them anyway
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  always_ff @(posedge i_sys_clk) begin
    sync1_reg <= {i_shift_clock_pin, i_chain_in, i_chip_sel_n, i_read_conv_n, i_ext_clk_sel};
    sync2_reg <= sync1_reg;
  end
  wire sclk_s = sync2_reg[4];
  wire chain_s = sync2_reg[3];
  wire cs_n_s = sync2_reg[2];
  wire rc_s = sync2_reg[1];
  wire ext_s = sync2_reg[0];

  logic sclk_d_reg;
  always_ff @(posedge i_sys_clk) begin
    sclk_d_reg <= sclk_s;
  end
  wire sclk_fall = sclk_d_reg & ~sclk_s;
  wire read_en = ~cs_n_s & rc_s;

  // clamp: the core may report beyond the range, never wrap
  wire signed [WORD_BITS:0] pos_fs = (WORD_BITS + 1)'(signed'({1'b0, `ADC_CODE_POS_FS}));
  wire signed [WORD_BITS:0] neg_fs = (WORD_BITS + 1)'(signed'({1'b1, `ADC_CODE_NEG_FS}));
  wire [WORD_BITS-1:0] clamped =
    (i_result_raw > pos_fs) ? WORD_BITS'(`ADC_CODE_POS_FS) :
    (i_result_raw < neg_fs) ? WORD_BITS'(`ADC_CODE_NEG_FS) :
    i_result_raw[WORD_BITS-1:0];

  // output shift register; chain bits enter at the bottom
  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] shift_next;
  logic [4:0] bit_cnt_reg;
  logic tag_cap_reg;
  adc_pkg::adc_int_state_e st_reg;
  logic [7:0] half_cnt_reg;
  wire int_mode = ~ext_s;
  wire int_tick = adc_int_high(st_reg) && (half_cnt_reg == 8'h00);
  wire ext_shift = ext_s & read_en & sclk_fall;
  wire do_shift = ext_shift | int_tick;
  // ext mode pulls chain bits in one per fall; internal mode fills with captured level
  wire fill_bit = int_mode ? tag_cap_reg : chain_s;
  assign shift_next = {shift_reg[WORD_BITS-2:0], fill_bit};

  wire int_start = int_mode & read_en & (st_reg == adc_pkg::ADC_IDLE) & (bit_cnt_reg == 5'h00) & o_busy;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      shift_reg <= '0;
      bit_cnt_reg <= 5'h00;
      tag_cap_reg <= 1'b0;
      o_busy <= 1'b1;
    end else if (i_result_load) begin
      // hazard: a load during an active external read would lose data
      shift_reg <= clamped;
      bit_cnt_reg <= 5'h00;
      o_busy <= 1'b1;
    end else begin
      if (int_start) begin
        tag_cap_reg <= chain_s;
      end
      if (do_shift) begin
        shift_reg <= shift_next;
        if (bit_cnt_reg != 5'h1f) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
    end
  end

  // internal clock: 12 pulses then low
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_reg <= adc_pkg::ADC_IDLE;
      half_cnt_reg <= 8'h00;
    end else begin
      unique case (st_reg)
        adc_pkg::ADC_IDLE: begin
          if (int_start) begin
            st_reg <= adc_pkg::ADC_INT_LO;
            half_cnt_reg <= 8'(`ADC_INT_HALF_CYC - 1);
          end
        end
        adc_pkg::ADC_INT_LO: begin
          if (half_cnt_reg == 8'h00) begin
            st_reg <= adc_pkg::ADC_INT_HI;
            half_cnt_reg <= 8'(`ADC_INT_HALF_CYC - 1);
          end else begin
            half_cnt_reg <= half_cnt_reg - 8'h01;
          end
        end
        adc_pkg::ADC_INT_HI: begin
          if (half_cnt_reg != 8'h00) begin
            half_cnt_reg <= half_cnt_reg - 8'h01;
          end else if (bit_cnt_reg == LAST_BIT) begin
            st_reg <= adc_pkg::ADC_IDLE;
          end else begin
            st_reg <= adc_pkg::ADC_INT_LO;
            half_cnt_reg <= 8'(`ADC_INT_HALF_CYC - 1);
          end
        end
      endcase
    end
  end

  // after the word, internal mode shows the captured chain level
  wire int_done = int_mode & (bit_cnt_reg >= 5'(WORD_BITS));
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_serial_output <= 1'b0;
      o_int_clock <= 1'b0;
    end else begin
      o_serial_output <= int_done ? tag_cap_reg : shift_reg[WORD_BITS-1];
      o_int_clock <= adc_int_high(st_reg);
    end
  end

  // watch-only copy of the chain level taken at the first external shift of a word
  logic sep_cap_reg;
  always_ff @(posedge i_sys_clk) begin
    if (ext_shift && !i_result_load && (bit_cnt_reg == 5'h00)) begin
      sep_cap_reg <= chain_s;
    end
  end

  // watch-only count of internal shift ticks since the transfer began
  logic [4:0] int_pulse_cnt_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || int_start) begin
      int_pulse_cnt_reg <= 5'h00;
    end else if (int_tick && (int_pulse_cnt_reg != 5'h1f)) begin
      int_pulse_cnt_reg <= int_pulse_cnt_reg + 5'h01;
    end
  end

  // separator slot: the twelfth fall shows the chain level of the first fall
  a_separator_bit: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (ext_shift && !i_result_load && bit_cnt_reg == LAST_BIT) |=> ##1 (o_serial_output == sep_cap_reg))
    else $error("separator bit not taken from chain input");

  a_shift_order: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (do_shift && !i_result_load) |=> (shift_reg[0] == $past(fill_bit)) &&
      (shift_reg[WORD_BITS-1] == $past(shift_reg[WORD_BITS-2])))
    else $error("shift order broken");

  // a fall while deselected or converting must leave the word alone
  a_deselect_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (sclk_fall && !read_en && !int_tick && !i_result_load) |=> $stable(shift_reg))
    else $error("shift taken while deselected");

  a_msb_first: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_result_load && ext_s && i_result_raw <= pos_fs && i_result_raw >= neg_fs)
      |=> ##1 (o_serial_output == $past(i_result_raw[WORD_BITS-1], 2)))
    else $error("msb not shown after load");

  a_clamp_high: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_result_load && i_result_raw > pos_fs) |=> shift_reg == WORD_BITS'(`ADC_CODE_POS_FS))
    else $error("positive overrange not clamped");

  a_clamp_low: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_result_load && i_result_raw < neg_fs) |=> shift_reg == WORD_BITS'(`ADC_CODE_NEG_FS))
    else $error("negative overrange not clamped");

  a_tag_capture: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (int_start && !i_result_load) |=> tag_cap_reg == $past(chain_s))
    else $error("chain level not captured at transfer start");

  a_int_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (int_done && !i_result_load) |=> o_serial_output == $past(tag_cap_reg))
    else $error("internal mode does not hold chain level");

  a_int_twelve: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    ((st_reg != adc_pkg::ADC_IDLE) ##1 (st_reg == adc_pkg::ADC_IDLE)) |-> (int_pulse_cnt_reg == 5'(WORD_BITS)))
    else $error("internal transfer not twelve pulses");

  // after the last pulse the internal clock rests low
  a_int_clock_rest: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (st_reg == adc_pkg::ADC_IDLE) |=> !o_int_clock)
    else $error("internal clock not resting low");
endmodule // adc_chain

// [dv/adc_host_model.sv]
`timescale 1ns/1ps
module adc_host_model (
  // link pins
  output logic o_shift_clock_pin,
  output logic o_chain_in,
  input wire logic i_serial_output,
  // sampled bit
  output logic o_got,
  output logic o_bit
);
  initial {o_shift_clock_pin, o_chain_in, o_got, o_bit} = 4'h8;
  // clock stands high outside frames; frames only while busy is high
  task automatic frame(input int n, input logic [63:0] tags);
    for (int k = 0; k <= n; k++) begin
      #30 o_bit = i_serial_output;
      o_got = 1'b1;
      o_chain_in = tags[k];
      #30 o_got = 1'b0;
      if (k < n) begin
        o_shift_clock_pin = 1'b0;
        #65 o_shift_clock_pin = 1'b1;
      end
    end
  endtask
endmodule // adc_host_model

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic cs_n = 1'b0;
  logic rc_n = 1'b1;
  logic ext = 1'b1;
  logic load = 1'b0;
  logic signed [12:0] raw = 13'h0000;
  logic [11:0] w;
  logic [63:0] tags;
  logic prev, pin, chain, sout, iclk, busy, got, hbit;
  logic exp_q[$];
  logic int_q[$];
  int mismatches = 0;
  int n_checks = 0;
  int seed = 18519;
  int cyc = 0;
  int np = 0;
  adc_chain dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_shift_clock_pin(pin), .i_chain_in(chain),
    .i_chip_sel_n(cs_n), .i_read_conv_n(rc_n), .i_ext_clk_sel(ext), .i_result_load(load),
    .i_result_raw(raw), .o_serial_output(sout), .o_int_clock(iclk), .o_busy(busy));
  adc_host_model host (.o_shift_clock_pin(pin), .o_chain_in(chain), .i_serial_output(sout),
    .o_got(got), .o_bit(hbit));
  always #5 i_sys_clk = ~i_sys_clk;
  task automatic check_bit(input string name, input logic e, input logic s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", name, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [11:0] clamp(input logic signed [12:0] v);
    return (v > 2047) ? 12'h07ff : (v < -2048) ? 12'h0800 : v[11:0];
  endfunction
  task automatic pulse();
    @(negedge i_sys_clk) load = 1'b1;
    @(negedge i_sys_clk) load = 1'b0;
    repeat (5) @(negedge i_sys_clk);
  endtask
  // budget covers six frames and one internal transfer with margin
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      finish_test();
    end
  end
  always @(posedge got) begin
    if (exp_q.size() == 0) check_bit("queue", 1'b1, 1'b0);
    else check_bit("serial_output", exp_q.pop_front(), hbit);
  end
  // internal transfer: each rising internal clock shows the next bit
  always @(negedge i_sys_clk) begin
    if (iclk === 1'b1 && prev === 1'b0) begin
      np++;
      if (int_q.size() == 0) check_bit("int_queue", 1'b1, 1'b0);
      else check_bit("int_bit", int_q.pop_front(), sout);
    end
    prev = iclk;
  end
  initial begin
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_reset = 1'b0;
    check_bit("busy", 1'b1, busy);
    for (int t = 0; t < 6; t++) begin
      @(negedge i_sys_clk);
      raw = 13'($random(seed));
      raw[12] = raw[11];
      if (t < 2) raw = t ? 13'h1000 : 13'h0fff;
      tags = {$random(seed), $random(seed)} & 64'hffff_ffff_ffff_fffe;
      cs_n = (t == 2);
      w = clamp(raw);
      pulse();
      for (int j = 0; j <= 25; j++) exp_q.push_back(cs_n ? w[11] : j < 12 ? w[11 - j] : tags[j - 12]);
      host.frame(25, tags);
      $display("test %0d done", t);
    end
    // internal clock mode, chain level left by the last frame
    @(negedge i_sys_clk);
    ext = 1'b0;
    cs_n = 1'b0;
    raw = 13'h05a3;
    w = clamp(raw);
    for (int j = 0; j < 12; j++) int_q.push_back(w[11 - j]);
    pulse();
    repeat (1100) @(negedge i_sys_clk);
    check_bit("int_pulses", 1'b1, np == 12);
    check_bit("int_hold", tags[25], sout);
    $display("test internal done");
    finish_test();
  end
endmodule // tb
